// File: hdl/tag_activation_state_machine.sv
// Activation state machine of a contactless tag
`timescale 1ns/1ps
module tag_activation_state_machine #(
  // Serial bytes; SN0 value is arbitrary
  parameter logic [55:0] UID = 56'h1122_3344_5566_77
) (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  // Decoded frames
  input  wire tag_act_pkg::frame_s     frame_i,
  // Response request
  output tag_act_pkg::resp_s           resp_o,
  // Status
  output tag_act_pkg::act_state_e      state_o,
  output logic                         halted_o,
  output logic                         error_o
);
  import tag_act_pkg::*;

  act_state_e state_q;
  act_state_e state_d;
  logic       halted_q;
  resp_s      resp_q;
  resp_s      resp_d;
  logic       error_q;
  logic       err_d;
  logic [7:0] bcc0;
  logic [7:0] bcc1;

  logic is_reqa;
  logic is_wupa;
  logic is_read0;
  logic is_halt;
  logic sel1_full;
  logic sel2_full;

  // Cascade tag ahead of first three serial bytes
  uid_check_byte u_bcc0 (
    .part_i ({CASCADE_TAG, UID[55:32]}),
    .bcc_o  (bcc0)
  );
  uid_check_byte u_bcc1 (
    .part_i (UID[31:0]),
    .bcc_o  (bcc1)
  );

  assign is_reqa   = frame_i.valid && frame_i.cmd == CMD_REQA;
  assign is_wupa   = frame_i.valid && frame_i.cmd == CMD_WUPA;
  assign is_halt   = frame_i.valid && frame_i.cmd == CMD_HALT;
  assign is_read0  = frame_i.valid && frame_i.cmd == CMD_READ
                     && frame_i.arg == PAGE_ZERO;
  assign sel1_full = frame_i.arg == NVB_FULL;
  assign sel2_full = frame_i.arg == NVB_FULL;

  always_comb
  begin
    state_d = state_q;
    resp_d  = '0;
    err_d   = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        // Wake on REQA or WUPA only
        if (is_wupa || (is_reqa && !halted_q))
        begin
          state_d = ST_UID1;
          resp_d  = '{1'b1, RK_ATQA, 8'h00, RSP_LEN_ATQA};
        end
        // Anything else is an error, stay idle
        else if (frame_i.valid)
          err_d = 1'b1;
      end
      ST_HALT:
      begin
        if (is_wupa)
        begin
          state_d = ST_UID1;
          resp_d  = '{1'b1, RK_ATQA, 8'h00, RSP_LEN_ATQA};
        end
        else if (frame_i.valid)
          err_d = 1'b1;
      end
      ST_UID1:
      begin
        if (frame_i.valid && frame_i.cmd == CMD_SEL_CL1)
        begin
          if (sel1_full)
          begin
            state_d = ST_UID2;
            resp_d  = '{1'b1, RK_SAK, SAK_CASCADE, RSP_LEN_SAK};
          end
          else
            resp_d = '{1'b1, RK_UID, bcc0, RSP_LEN_UID};
        end
        else if (is_read0)
        begin
          state_d = ST_ACTIVE;
          resp_d  = '{1'b1, RK_READ, PAGE_ZERO, RSP_LEN_READ};
        end
        else if (frame_i.valid)
        begin
          // Fall back according to halted flag
          err_d   = 1'b1;
          state_d = halted_q ? ST_HALT : ST_IDLE;
        end
      end
      ST_UID2:
      begin
        if (frame_i.valid && frame_i.cmd == CMD_SEL_CL2)
        begin
          if (sel2_full)
          begin
            state_d = ST_ACTIVE;
            resp_d  = '{1'b1, RK_SAK, SAK_DONE, RSP_LEN_SAK};
          end
          else
            resp_d = '{1'b1, RK_UID, bcc1, RSP_LEN_UID};
        end
        // Page-0 read also goes active here
        else if (is_read0)
        begin
          state_d = ST_ACTIVE;
          resp_d  = '{1'b1, RK_READ, PAGE_ZERO, RSP_LEN_READ};
        end
        else if (frame_i.valid)
        begin
          err_d   = 1'b1;
          state_d = halted_q ? ST_HALT : ST_IDLE;
        end
      end
      ST_ACTIVE:
      begin
        if (frame_i.valid && frame_i.cmd == CMD_READ)
          resp_d = '{1'b1, RK_READ, frame_i.arg, RSP_LEN_READ};
        else if (frame_i.valid && frame_i.cmd == CMD_WRITE)
          resp_d = '{1'b1, RK_WRITE, frame_i.arg, WRITE_LEN};
        // Halted wait left only via WUPA
        else if (is_halt)
          state_d = ST_HALT;
        else if (frame_i.valid)
        begin
          err_d   = 1'b1;
          state_d = halted_q ? ST_HALT : ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Halted flag: HALT from active sets, WUPA from idle clears
  // Kept through a wake from halt so later errors fall back to halt
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      halted_q <= 1'b0;
    else if (state_q == ST_ACTIVE && is_halt)
      halted_q <= 1'b1;
    else if (is_wupa && state_q == ST_IDLE)
      halted_q <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      resp_q  <= '0;
      error_q <= 1'b0;
    end
    else
    begin
      resp_q  <= resp_d;
      error_q <= err_d;
    end
  end

  assign state_o  = state_q;
  assign halted_o = halted_q;
  assign resp_o   = resp_q;
  assign error_o  = error_q;

  a_reset_idle: assert property (@(posedge mclk_i)
    $rose(rst_b_i) |-> state_q == ST_IDLE)
    else $error("not idle after reset");
  a_idle_wake: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_IDLE && (is_wupa || (is_reqa && !halted_q))
    |=> state_q == ST_UID1 && resp_q.kind == RK_ATQA)
    else $error("wake command did not reach first UID state");
  a_idle_exit: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_IDLE && state_d != ST_IDLE |->
    is_wupa || (is_reqa && !halted_q))
    else $error("idle left without wake command");
  a_idle_error: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_IDLE && frame_i.valid && !is_reqa && !is_wupa
    |=> state_q == ST_IDLE && error_q)
    else $error("idle error not flagged");
  a_halt_entry: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_ACTIVE && is_halt |=> state_q == ST_HALT && halted_q)
    else $error("halt not entered");
  a_halt_hold: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_HALT && !is_wupa |=> state_q == ST_HALT)
    else $error("halt left without WUPA");
  a_halt_error: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_HALT && frame_i.valid && !is_wupa |=> error_q)
    else $error("halt error not flagged");
  a_sel1_move: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_UID1 && frame_i.valid && frame_i.cmd == CMD_SEL_CL1
    && sel1_full |=> state_q == ST_UID2 && resp_q.valid)
    else $error("level-1 select failed");
  a_read0_skip: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (state_q == ST_UID1 || state_q == ST_UID2) && is_read0
    |=> state_q == ST_ACTIVE)
    else $error("page-0 read not active");
  a_sel2_sak: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q == ST_UID2 && frame_i.valid && frame_i.cmd == CMD_SEL_CL2
    && sel2_full |=> resp_q.data == SAK_DONE && state_q == ST_ACTIVE)
    else $error("level-2 SAK wrong");
  a_error_return: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q inside {ST_UID1, ST_UID2, ST_ACTIVE} && err_d
    |=> state_q == ($past(halted_q) ? ST_HALT : ST_IDLE))
    else $error("error return wrong");
  a_reqa_halted: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    state_q inside {ST_IDLE, ST_HALT} && halted_q && is_reqa
    |=> state_q != ST_UID1)
    else $error("REQA woke halted tag");

  c_full_select: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_q == ST_UID2 ##1 state_q == ST_ACTIVE);
  c_halt_wake: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_q == ST_HALT ##1 state_q == ST_UID1);
  c_error_back: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_q == ST_ACTIVE ##1 state_q == ST_IDLE);
  c_halted_fallback: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_q == ST_UID1 && halted_q) ##1 state_q == ST_HALT);
endmodule // tag_activation_state_machine

// File: hdl/uid_check_byte.sv
// Cascade-level check byte over a four-byte identifier part
`timescale 1ns/1ps
module uid_check_byte (
  // Identifier bytes
  input  wire logic [31:0] part_i,
  // Exclusive-or of all four bytes
  output logic      [7:0]  bcc_o
);
  assign bcc_o = part_i[31:24] ^ part_i[23:16] ^ part_i[15:8] ^ part_i[7:0];
endmodule // uid_check_byte

// File: include/tag_act_pkg.sv
// Package with command codes, frame carriers and activation constants
package tag_act_pkg;

  // Command opcodes as decoded by the framing layer
  localparam logic [7:0] CMD_REQA    = 8'h26;
  localparam logic [7:0] CMD_WUPA    = 8'h52;
  localparam logic [7:0] CMD_SEL_CL1 = 8'h93;
  localparam logic [7:0] CMD_SEL_CL2 = 8'h95;
  localparam logic [7:0] CMD_READ    = 8'h30;
  localparam logic [7:0] CMD_WRITE   = 8'ha2;
  localparam logic [7:0] CMD_HALT    = 8'h50;
  // Second byte of a SELECT carrying a full UID part
  localparam logic [7:0] NVB_FULL    = 8'h70;

  localparam logic [7:0] CASCADE_TAG = 8'h88;
  localparam logic [7:0] SAK_CASCADE = 8'h04;
  localparam logic [7:0] SAK_DONE    = 8'h00;
  localparam logic [7:0] PAGE_ZERO   = 8'h00;

  // Response lengths in bytes
  localparam logic [4:0] RSP_LEN_UID   = 5'd5;
  localparam logic [4:0] RSP_LEN_SAK   = 5'd1;
  localparam logic [4:0] RSP_LEN_READ  = 5'd16;
  localparam logic [4:0] RSP_LEN_ATQA  = 5'd2;
  localparam logic [4:0] RSP_LEN_ACK   = 5'd1;
  localparam logic [4:0] WRITE_LEN     = 5'd4;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_UID1   = 5'b00010,
    ST_UID2   = 5'b00100,
    ST_ACTIVE = 5'b01000,
    ST_HALT   = 5'b10000
  } act_state_e;

  // Decoded frame from the framing layer, one-cycle valid
  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] arg;
  } frame_s;

  // Action request to the response and memory side
  typedef struct packed {
    logic       valid;
    logic [2:0] kind;
    logic [7:0] data;
    logic [4:0] len;
  } resp_s;

  localparam logic [2:0] RK_ATQA = 3'd1;
  localparam logic [2:0] RK_UID  = 3'd2;
  localparam logic [2:0] RK_SAK  = 3'd3;
  localparam logic [2:0] RK_READ = 3'd4;
  localparam logic [2:0] RK_WRITE = 3'd5;

endpackage

// File: tb/reader_model.sv
// Reader model that issues decoded command frames to the tag
`timescale 1ns/1ps
module reader_model (
  // Clock
  input  wire logic             mclk_i,
  // Frames toward the tag
  output tag_act_pkg::frame_s   frame_o
);
  initial frame_o = '0;

  // One-cycle frame; outside it the fields show a changed pattern
  task automatic send(input logic [7:0] cmd, input logic [7:0] arg);
    @(posedge mclk_i);
    frame_o <= {1'b1, cmd, arg};
    @(posedge mclk_i);
    frame_o <= {1'b0, ~cmd, ~arg};
  endtask
endmodule // reader_model

// File: tb/tb_tag_activation_state_machine.sv
// Self-checking bench for the tag activation state machine
`timescale 1ns/1ps
module tb_tag_activation_state_machine;
  import tag_act_pkg::*;

  localparam logic [55:0] U = 56'h0a1b_2c3d_4e5f_60;
  localparam logic [7:0]  BCC0 = 8'h88 ^ U[55:48] ^ U[47:40] ^ U[39:32];
  localparam logic [7:0]  BCC1 = U[31:24] ^ U[23:16] ^ U[15:8] ^ U[7:0];

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] arg;
    act_state_e st;
    logic [2:0] kind;
    logic [7:0] data;
    logic [4:0] len;
    // Expected error pulse, then expected halted flag
    logic [1:0] err_hlt;
  } row_s;

  logic       mclk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  frame_s     frame;
  resp_s      resp;
  act_state_e state;
  logic       halted;
  logic       error;
  int         mismatches = 0;
  int         n_checks = 0;
  int         cycles = 0;

  // Kind 0 means no response is expected
  row_s rows [25] = '{
    '{CMD_READ, 8'h00, ST_IDLE, 3'd0, 8'h00, 5'd0, 2'b10},
    '{CMD_REQA, 8'h00, ST_UID1, RK_ATQA, 8'h00, RSP_LEN_ATQA, 2'b00},
    '{CMD_SEL_CL1, 8'h20, ST_UID1, RK_UID, BCC0, RSP_LEN_UID, 2'b00},
    '{CMD_SEL_CL1, NVB_FULL, ST_UID2, RK_SAK, SAK_CASCADE, 5'd1, 2'b00},
    '{CMD_SEL_CL2, 8'h20, ST_UID2, RK_UID, BCC1, RSP_LEN_UID, 2'b00},
    '{CMD_SEL_CL2, NVB_FULL, ST_ACTIVE, RK_SAK, SAK_DONE, 5'd1, 2'b00},
    '{CMD_READ, 8'h05, ST_ACTIVE, RK_READ, 8'h05, 5'd16, 2'b00},
    '{CMD_WRITE, 8'h06, ST_ACTIVE, RK_WRITE, 8'h00, 5'd4, 2'b00},
    '{CMD_REQA, 8'h00, ST_IDLE, 3'd0, 8'h00, 5'd0, 2'b10},
    '{CMD_WUPA, 8'h00, ST_UID1, RK_ATQA, 8'h00, RSP_LEN_ATQA, 2'b00},
    '{CMD_WRITE, 8'h00, ST_IDLE, 3'd0, 8'h00, 5'd0, 2'b10},
    '{CMD_REQA, 8'h00, ST_UID1, RK_ATQA, 8'h00, RSP_LEN_ATQA, 2'b00},
    '{CMD_SEL_CL1, NVB_FULL, ST_UID2, RK_SAK, SAK_CASCADE, 5'd1, 2'b00},
    '{CMD_HALT, 8'h00, ST_IDLE, 3'd0, 8'h00, 5'd0, 2'b10},
    '{CMD_REQA, 8'h00, ST_UID1, RK_ATQA, 8'h00, RSP_LEN_ATQA, 2'b00},
    '{CMD_READ, 8'h00, ST_ACTIVE, RK_READ, 8'h00, 5'd16, 2'b00},
    '{CMD_HALT, 8'h00, ST_HALT, 3'd0, 8'h00, 5'd0, 2'b01},
    '{CMD_REQA, 8'h00, ST_HALT, 3'd0, 8'h00, 5'd0, 2'b11},
    '{CMD_READ, 8'h00, ST_HALT, 3'd0, 8'h00, 5'd0, 2'b11},
    '{CMD_WUPA, 8'h00, ST_UID1, RK_ATQA, 8'h00, RSP_LEN_ATQA, 2'b01},
    '{CMD_SEL_CL1, NVB_FULL, ST_UID2, RK_SAK, SAK_CASCADE, 5'd1, 2'b01},
    '{CMD_READ, 8'h00, ST_ACTIVE, RK_READ, 8'h00, 5'd16, 2'b01},
    '{CMD_REQA, 8'h00, ST_HALT, 3'd0, 8'h00, 5'd0, 2'b11},
    '{CMD_WUPA, 8'h00, ST_UID1, RK_ATQA, 8'h00, RSP_LEN_ATQA, 2'b01},
    '{CMD_WRITE, 8'h00, ST_HALT, 3'd0, 8'h00, 5'd0, 2'b11}
  };

  always #2.5 mclk_i = ~mclk_i;

  reader_model reader_model_inst (
    .mclk_i  (mclk_i),
    .frame_o (frame)
  );

  tag_activation_state_machine #(.UID(U)) tag_activation_state_machine_inst (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .frame_i  (frame),
    .resp_o   (resp),
    .state_o  (state),
    .halted_o (halted),
    .error_o  (error)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard sized well above the expected run of about 85 cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1 check(16'(state), 16'(ST_IDLE));
    foreach (rows[i])
    begin
      reader_model_inst.send(rows[i].cmd, rows[i].arg);
      #1;
      check(16'(state), 16'(rows[i].st));
      check(16'(error), 16'(rows[i].err_hlt[1]));
      check(16'(halted), 16'(rows[i].err_hlt[0]));
      check(16'(resp.valid), 16'(rows[i].kind != 3'd0));
      if (rows[i].kind != 3'd0)
      begin
        check(16'({resp.kind, resp.len}),
              16'({rows[i].kind, rows[i].len}));
        if (rows[i].kind != RK_ATQA && rows[i].kind != RK_WRITE)
          check(16'(resp.data), 16'(rows[i].data));
      end
    end
    // Reset in mid-session from halt lands straight in idle
    reader_model_inst.send(CMD_WUPA, 8'h00);
    reader_model_inst.send(CMD_READ, 8'h00);
    #1 check(16'(state), 16'(ST_ACTIVE));
    reader_model_inst.send(CMD_HALT, 8'h00);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    #1 check({15'(state), halted}, {15'(ST_IDLE), 1'b0});
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    // Back in idle only REQA or WUPA are accepted
    reader_model_inst.send(CMD_SEL_CL1, NVB_FULL);
    #1 check({15'(state), error}, {15'(ST_IDLE), 1'b1});
    reader_model_inst.send(CMD_REQA, 8'h00);
    #1 check(16'(state), 16'(ST_UID1));
    conclude();
  end
endmodule // tb_tag_activation_state_machine
